/* rtl/adcsq_top.sv */
/*
 * conversion sequencer: start control, single/scan channel stepping, timing,
 * end flag and done irq, result storage and a result stream through a fifo.
 * assumes control inputs are synchronous to clk_sys; the analog comparator
 * answers each trial on cmp_in one cycle after dac_code changes.
 */
`timescale 1ns/1ns
`default_nettype none
module adcsq_top (
	input  wire logic                        clk_sys,
	input  wire logic                        reset,
	input  wire logic                        start_set,
	input  wire logic                        start_clear,
	input  wire logic                        ctrl_write,
	input  wire logic                        scan_mode,
	input  wire logic                        conv_speed_select,
	input  wire logic                        group_select_bit,
	input  wire logic                        channel_select_bit1,
	input  wire logic                        channel_select_bit0,
	input  wire logic                        end_irq_enable,
	input  wire logic                        ext_trigger_enable,
	input  wire logic                        ext_trigger_pin,
	input  wire logic                        status_read,
	input  wire logic                        end_flag_clear,
	input  wire logic                        cmp_in,
	input  wire logic [adcsq_pkg::CH_W-1:0]  rd_ch,
	input  wire logic                        rd_upper,
	input  wire logic                        rd_lower,
	input  wire logic                        stream_ready,
	output logic                             conv_start_bit,
	output logic                             conv_end_flag,
	output logic                             conv_done_irq,
	output logic                             sampling,
	output logic      [adcsq_pkg::CH_W-1:0]  active_ch,
	output logic      [adcsq_pkg::RES_W-1:0] dac_code,
	output logic      [7:0]                  rd_data,
	output logic                             stream_valid,
	output logic      [adcsq_pkg::FIFO_W-1:0] stream_data,
	output logic                             stream_overrun
);
	adcsq_pkg::adcsq_state_t state;
	adcsq_pkg::adcsq_state_t next_state;
	logic [adcsq_pkg::CNT_W-1:0] cnt;
	logic                        trig_prev;
	logic                        read_armed;
	logic [adcsq_pkg::RES_W-1:0] sar;
	logic [3:0]                  bit_idx;

	// speed-dependent timing
	wire [adcsq_pkg::CNT_W-1:0] sync_len = conv_speed_select ?
		adcsq_pkg::CNT_W'(adcsq_pkg::SYNC_FAST) :
		adcsq_pkg::CNT_W'(adcsq_pkg::SYNC_SLOW);
	wire [adcsq_pkg::CNT_W-1:0] conv_len = conv_speed_select ?
		adcsq_pkg::CNT_W'(adcsq_pkg::CONV_FAST - 1) :
		adcsq_pkg::CNT_W'(adcsq_pkg::CONV_SLOW - 1);
	wire [adcsq_pkg::CNT_W-1:0] spl_len = conv_speed_select ?
		adcsq_pkg::CNT_W'(adcsq_pkg::SPL_FAST) :
		adcsq_pkg::CNT_W'(adcsq_pkg::SPL_SLOW);

	// trial bits every 8 (fast) or 16 (slow) states once sampling ends
	wire [adcsq_pkg::CNT_W-1:0] step_len = conv_speed_select ?
		adcsq_pkg::CNT_W'(8) : adcsq_pkg::CNT_W'(16);

	// external trigger falling edge
	wire trig_fall  = ext_trigger_enable && trig_prev && !ext_trigger_pin;
	wire start_req  = start_set || trig_fall;
	// software clear yields to a start in the same write; abort path
	wire stop_req   = start_clear && !start_req;

	// channel choice: single picks one, scan walks group from first input
	wire [1:0] sel_low   = {channel_select_bit1, channel_select_bit0};
	wire [adcsq_pkg::CH_W-1:0] first_ch = scan_mode ?
		{group_select_bit, 2'b00} : {group_select_bit, sel_low};
	wire last_in_group = !scan_mode || (active_ch[1:0] == sel_low);

	wire conv_done   = (state == adcsq_pkg::ADCSQ_CONV) && (cnt == conv_len);
	wire in_sample   = (state == adcsq_pkg::ADCSQ_CONV) && (cnt < spl_len);
	wire trial_tick  = (state == adcsq_pkg::ADCSQ_CONV) && !in_sample &&
		(((cnt - spl_len) & (step_len - 1'b1)) == '0) && (bit_idx != 4'h0);
	wire [adcsq_pkg::RES_W-1:0] final_result = sar;

	wire fifo_in_ready;

	assign sampling = in_sample;
	assign dac_code = sar;
	assign conv_done_irq = conv_end_flag && end_irq_enable;

	always_comb begin
		next_state = state;
		case (state)
			adcsq_pkg::ADCSQ_IDLE: begin
				if (start_req) begin
					next_state = adcsq_pkg::ADCSQ_SYNC;
				end
			end
			adcsq_pkg::ADCSQ_SYNC: begin
				if (stop_req) begin
					next_state = adcsq_pkg::ADCSQ_IDLE;
				end else if (cnt == sync_len - 1'b1) begin
					// counted from zero: delay plus conversion stays within the maximum
					next_state = adcsq_pkg::ADCSQ_CONV;
				end
			end
			adcsq_pkg::ADCSQ_CONV: begin
				if (stop_req) begin
					next_state = adcsq_pkg::ADCSQ_IDLE;
				end else if (conv_done && !scan_mode) begin
					// a start landing on the final state is honoured, not lost
					next_state = start_req ? adcsq_pkg::ADCSQ_SYNC : adcsq_pkg::ADCSQ_IDLE;
				end
			end
			default: begin
				next_state = adcsq_pkg::ADCSQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state     <= adcsq_pkg::ADCSQ_IDLE;
			trig_prev <= 1'b1;
		end else begin
			state     <= next_state;
			trig_prev <= ext_trigger_pin;
		end
	end

	// state-position counter; restarts at each conversion boundary
	always_ff @(posedge clk_sys) begin
		if (reset || state != next_state || conv_done) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	// start bit: set by software or trigger, cleared by software or single end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			conv_start_bit <= 1'b0;
		end else if (start_req) begin
			conv_start_bit <= 1'b1;
		end else if (start_clear || (conv_done && !scan_mode)) begin
			conv_start_bit <= 1'b0;
		end
	end

	// channel stepping; a restart always returns to the first input
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			active_ch <= '0;
		end else if (state == adcsq_pkg::ADCSQ_IDLE || state == adcsq_pkg::ADCSQ_SYNC) begin
			active_ch <= first_ch;
		end else if (conv_done && scan_mode) begin
			active_ch <= last_in_group ? first_ch : active_ch + 1'b1;
		end
	end

	// successive approximation, msb first
	always_ff @(posedge clk_sys) begin
		if (reset || !(state == adcsq_pkg::ADCSQ_CONV) || in_sample) begin
			sar     <= 10'h200;
			bit_idx <= 4'(adcsq_pkg::RES_W);
		end else if (trial_tick) begin
			sar[bit_idx - 1'b1] <= cmp_in;
			if (bit_idx > 4'h1) begin
				sar[bit_idx - 4'h2] <= 1'b1;
			end
			bit_idx <= bit_idx - 1'b1;
		end
	end

	// end flag: only a write after a read clears it; set beats clear
	wire flag_set = conv_done && !stop_req && (!scan_mode || last_in_group);
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			conv_end_flag <= 1'b0;
			read_armed    <= 1'b0;
		end else begin
			if (flag_set) begin
				conv_end_flag <= 1'b1;
			end else if (end_flag_clear && read_armed) begin
				conv_end_flag <= 1'b0;
			end
			if (status_read && conv_end_flag) begin
				read_armed <= 1'b1;
			end else if (ctrl_write) begin
				read_armed <= 1'b0;
			end
		end
	end

	// result stream lost words when the consumer stalls too long
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stream_overrun <= 1'b0;
		end else if (conv_done && !stop_req && !fifo_in_ready) begin
			stream_overrun <= 1'b1;
		end
	end

	adcsq_result_mem u_mem (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.wr_en    (conv_done && !stop_req),
		.wr_ch    (active_ch),
		.wr_data  (final_result),
		.rd_ch    (rd_ch),
		.rd_upper (rd_upper),
		.rd_lower (rd_lower),
		.rd_data  (rd_data)
	);

	adcsq_fifo #(
		.WIDTH (adcsq_pkg::FIFO_W),
		.DEPTH (adcsq_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.in_valid  (conv_done && !stop_req),
		.in_ready  (fifo_in_ready),
		.in_data   ({active_ch, final_result}),
		.out_valid (stream_valid),
		.out_ready (stream_ready),
		.out_data  (stream_data)
	);
endmodule : adcsq_top
`default_nettype wire

/* rtl/adcsq_pkg.sv */
/*
 * constants for the converter sequencer: timing counts in states, channel and
 * result widths, fifo shape.
 * assumes one state equals one clk_sys cycle.
 */
// Behaviour
// - 10-bit result, single or scan modes
// - single mode converts one selected channel
// - start bit holds, self-clears on single-mode completion
// - completion sets end flag, irq if enabled
// - end flag cleared by read-then-write-zero
// - result lands in its channel's register
// - scan starts at group's first input
// - scan conversions follow back to back, cyclically
// - group end sets flag, restarts first
// - clearing start stops; restart from first
// - synchronization delay before sampling
// - first conversion 259-266 or 131-134 states
// - later scan conversions 256 or 128 states
// - trigger falling edge sets start when enabled
// - external start behaves like software start
// - channel bits plus mode choose inputs
// - speed bit selects 266 or 134 maximum
// - upper-byte read latches lower byte
package adcsq_pkg;
	localparam int RES_W        = 10;
	localparam int CH_W         = 3;
	localparam int NUM_CH       = 8;
	localparam int SYNC_SLOW    = 10;
	localparam int SYNC_FAST    = 6;
	localparam int CONV_SLOW    = 256;
	localparam int CONV_FAST    = 128;
	localparam int SPL_SLOW     = 63;
	localparam int SPL_FAST     = 31;
	localparam int CNT_W        = 9;
	localparam int FIFO_DEPTH   = 16;
	localparam int FIFO_W       = RES_W + CH_W;
	localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
	typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_SYNC, ADCSQ_CONV} adcsq_state_t;
endpackage : adcsq_pkg

/* rtl/adcsq_fifo.sv */
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock, synchronous active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none
module adcsq_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= rd_ptr + AW'(pop);
			count  <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : adcsq_fifo
`default_nettype wire

/* rtl/adcsq_result_mem.sv */
/*
 * eight result registers indexed by channel, plus the byte holding register.
 * assumes software reads upper byte before lower byte.
 */
`timescale 1ns/1ns
`default_nettype none
module adcsq_result_mem (
	input  wire logic                        clk_sys,
	input  wire logic                        reset,
	input  wire logic                        wr_en,
	input  wire logic [adcsq_pkg::CH_W-1:0]  wr_ch,
	input  wire logic [adcsq_pkg::RES_W-1:0] wr_data,
	input  wire logic [adcsq_pkg::CH_W-1:0]  rd_ch,
	input  wire logic                        rd_upper,
	input  wire logic                        rd_lower,
	output logic      [7:0]                  rd_data
);
	logic [adcsq_pkg::RES_W-1:0] mem [adcsq_pkg::NUM_CH];
	logic [1:0]                  hold;
	// upper byte is result[9:2]; lower byte carries result[1:0] in bits 7:6
	wire  [15:0]                 word = {mem[rd_ch], 6'h00};

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int i = 0; i < adcsq_pkg::NUM_CH; i++) begin
				mem[i] <= adcsq_pkg::RESULT_RESET;
			end
		end else if (wr_en) begin
			mem[wr_ch] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hold    <= 2'h0;
			rd_data <= 8'h00;
		end else if (rd_upper) begin
			hold    <= word[7:6];
			rd_data <= word[15:8];
		end else if (rd_lower) begin
			rd_data <= {hold, 6'h00};
		end
	end
endmodule : adcsq_result_mem
`default_nettype wire

/* verification/adcsq_top_props.sv */
/*
 * assertions on the adcsq_top ports, bound at the foot.
 * assumes one clk_sys domain with synchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none
module adcsq_top_props (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic start_set,
	input wire logic start_clear,
	input wire logic scan_mode,
	input wire logic conv_speed_select,
	input wire logic group_select_bit,
	input wire logic channel_select_bit1,
	input wire logic channel_select_bit0,
	input wire logic end_irq_enable,
	input wire logic end_flag_clear,
	input wire logic conv_start_bit,
	input wire logic conv_end_flag,
	input wire logic conv_done_irq,
	input wire logic sampling,
	input wire logic [2:0] active_ch
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic [6:0] spl_cnt;
	logic [8:0] gap;
	logic       gap_ok;
	logic       samp_d;
	// gap only trusted after a sampling start inside the same run
	always_ff @(posedge clk_sys) begin
		samp_d  <= sampling;
		spl_cnt <= sampling ? spl_cnt + 7'h01 : 7'h00;
		gap     <= (sampling && !samp_d) ? 9'h001 : gap + 9'h001;
		gap_ok  <= conv_start_bit && (gap_ok || (sampling && !samp_d));
	end
	irq_mirror_a: assert property (conv_done_irq == (conv_end_flag && end_irq_enable))
		else $error("irq not flag and enable");
	start_take_a: assert property (start_set |=> conv_start_bit)
		else $error("start bit not set");
	flag_clear_a: assert property ($fell(conv_end_flag) && !$past(reset)
		|-> $past(end_flag_clear)) else $error("flag fell unasked");
	sync_fast_a: assert property ($rose(conv_start_bit) && conv_speed_select
		|-> !sampling [*5] ##[1:4] sampling) else $error("sync delay off");
	spl_len_a: assert property ($fell(sampling) && conv_start_bit
		|-> spl_cnt == (conv_speed_select ? 7'h1f : 7'h3f)) else $error("sampling length off");
	scan_gap_a: assert property (sampling && !samp_d && gap_ok && scan_mode
		|-> gap == (conv_speed_select ? 9'h080 : 9'h100)) else $error("scan period off");
	single_end_a: assert property ($fell(conv_start_bit) && !$past(start_clear)
		&& !$past(reset) && !scan_mode |-> conv_end_flag) else $error("no flag at end");
	first_in_a: assert property ($rose(conv_start_bit) |-> ##12 active_ch ==
		{group_select_bit, channel_select_bit1 && !scan_mode, channel_select_bit0 && !scan_mode})
		else $error("wrong first input");
endmodule : adcsq_top_props
bind adcsq_top adcsq_top_props chk (.clk_sys, .reset, .start_set, .start_clear, .scan_mode,
	.conv_speed_select, .group_select_bit, .channel_select_bit1, .channel_select_bit0,
	.end_irq_enable, .end_flag_clear, .conv_start_bit, .conv_end_flag, .conv_done_irq,
	.sampling, .active_ch);
`default_nettype wire

/* verification/adcsq_cmp_model.sv */
/*
 * comparator stand-in: input n sits at level {n, 7'h2a}.
 * assumes dac_code carries the trial value.
 */
`timescale 1ns/1ns
`default_nettype none
module adcsq_cmp_model (
	input wire logic       clk_sys,
	input wire logic [2:0] active_ch,
	input wire logic [9:0] dac_code,
	output logic           cmp_in
);
	// answers one cycle late, as the analog side settles
	always_ff @(posedge clk_sys) begin
		cmp_in <= {active_ch, 7'h2a} >= dac_code;
	end
endmodule : adcsq_cmp_model
`default_nettype wire

/* verification/adcsq_top_bench.sv */
/*
 * bench for adcsq_top: single, scan into a full fifo, trigger, abort.
 * assumes adcsq_cmp_model fixes each input level.
 */
`timescale 1ns/1ns
`default_nettype none
module adcsq_top_bench;
	logic clk_sys, reset, start_set, start_clear, ctrl_write, status_read, end_flag_clear;
	logic scan_mode, conv_speed_select, group_select_bit, channel_select_bit1, channel_select_bit0;
	logic end_irq_enable, ext_trigger_enable, ext_trigger_pin, cmp_in, rd_upper, rd_lower;
	logic stream_ready, conv_start_bit, conv_end_flag, conv_done_irq, sampling, stream_valid;
	logic        stream_overrun;
	logic [2:0]  rd_ch, active_ch;
	logic [4:0]  cfg;
	logic [9:0]  dac_code;
	logic [7:0]  rd_data;
	logic [12:0] stream_data;
	int          n_fail, samples_checked;
	assign {scan_mode, conv_speed_select, group_select_bit, channel_select_bit1,
		channel_select_bit0} = cfg;
	adcsq_top uut (.*);
	adcsq_cmp_model cmp (.clk_sys, .active_ch, .dac_code, .cmp_in);
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [13:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task report_and_stop;
		if (n_fail == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop
	// scenarios need about 3000 cycles
	initial begin
		repeat (10000) @(posedge clk_sys);
		n_fail++;
		report_and_stop;
	end
	task automatic wait_for(ref logic s, input logic v);
		#1;
		for (int i = 0; i < 3000 && s !== v; i++) begin
			@(posedge clk_sys);
			#1;
		end
	endtask : wait_for
	task go(input logic on);
		@(posedge clk_sys) start_set <= on;
		start_clear <= !on;
		@(posedge clk_sys) start_set <= 1'b0;
		start_clear <= 1'b0;
	endtask : go
	task rd(input logic [2:0] ch, input logic [9:0] v);
		@(posedge clk_sys) rd_ch <= ch;
		rd_upper <= 1'b1;
		@(posedge clk_sys) rd_upper <= 1'b0;
		rd_lower <= 1'b1;
		#1 chk(rd_data, v[9:2]);
		@(posedge clk_sys) rd_lower <= 1'b0;
		#1 chk(rd_data, {v[1:0], 6'h00});
	endtask : rd
	task clr_flag;
		@(posedge clk_sys) status_read <= 1'b1;
		@(posedge clk_sys) status_read <= 1'b0;
		ctrl_write <= 1'b1;
		end_flag_clear <= 1'b1;
		@(posedge clk_sys) ctrl_write <= 1'b0;
		end_flag_clear <= 1'b0;
		#1;
	endtask : clr_flag
	task t_single;
		@(posedge clk_sys) cfg <= 5'h0d; // changed while stopped
		go(1'b1);
		wait_for(conv_start_bit, 1'b0);
		chk({conv_start_bit, conv_end_flag, conv_done_irq}, 3'h3);
		rd(3'h5, {3'h5, 7'h2a});
		@(posedge clk_sys) ctrl_write <= 1'b1;
		end_flag_clear <= 1'b1;
		@(posedge clk_sys) ctrl_write <= 1'b0;
		end_flag_clear <= 1'b0;
		#1 chk(conv_end_flag, 1'b1);
		clr_flag;
		chk({conv_end_flag, conv_done_irq}, 2'h0);
	endtask : t_single
	task t_scan;
		logic [2:0] c;
		@(posedge clk_sys) stream_ready <= 1'b0;
		cfg <= 5'h1e;
		go(1'b1);
		wait_for(stream_overrun, 1'b1);
		chk({stream_overrun, conv_start_bit, conv_end_flag}, 3'h7);
		go(1'b0);
		#1 chk(conv_start_bit, 1'b0);
		rd(3'h6, {3'h6, 7'h2a});
		@(posedge clk_sys) stream_ready <= 1'b1;
		#1;
		for (int i = 0; i < 16; i++) begin
			c = 3'h4 + 3'(i % 3);
			chk({stream_valid, stream_data}, {1'b1, c, c, 7'h2a});
			@(posedge clk_sys);
			#1;
		end
		chk(stream_valid, 1'b0);
	endtask : t_scan
	task t_trig;
		int n;
		clr_flag;
		@(posedge clk_sys) cfg <= 5'h02;
		ext_trigger_enable <= 1'b1;
		end_irq_enable <= 1'b0;
		@(posedge clk_sys) ext_trigger_pin <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 chk(conv_start_bit, 1'b1);
		// states from the edge that takes the trigger to the completion edge
		n = 1;
		while (conv_start_bit === 1'b1 && n < 400) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(14'(n), 14'(adcsq_pkg::SYNC_SLOW + adcsq_pkg::CONV_SLOW));
		chk({conv_end_flag, conv_done_irq}, 2'h2);
		rd(3'h2, {3'h2, 7'h2a});
		@(posedge clk_sys) ext_trigger_enable <= 1'b0;
		ext_trigger_pin <= 1'b1;
		end_irq_enable <= 1'b1;
		@(posedge clk_sys) ext_trigger_pin <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 chk(conv_start_bit, 1'b0);
		@(posedge clk_sys) ext_trigger_pin <= 1'b1;
	endtask : t_trig
	task t_abort;
		clr_flag;
		@(posedge clk_sys) cfg <= 5'h1f;
		go(1'b1);
		// stop inside the second channel so a restart must go back to the first
		repeat (200) @(posedge clk_sys);
		go(1'b0);
		#1 chk({conv_start_bit, conv_end_flag, stream_valid}, 3'h0);
		rd(3'h7, 10'h000);
		go(1'b1);
		wait_for(stream_valid, 1'b1);
		chk(stream_data, {3'h4, 3'h4, 7'h2a});
		go(1'b0);
	endtask : t_abort
	initial begin
		{start_set, start_clear, ctrl_write, status_read, end_flag_clear, rd_upper, rd_lower} = '0;
		{ext_trigger_enable, rd_ch, cfg} = '0;
		{end_irq_enable, ext_trigger_pin, stream_ready, reset} = 4'hf;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		t_single;
		t_scan;
		t_trig;
		t_abort;
		report_and_stop;
	end
endmodule : adcsq_top_bench
`default_nettype wire
